// ==== design/pfd_pump.sv ====
/*
 * Phase frequency detector with antibacklash overlap and pump mode
 * control. Assumes ref/feedback divider outputs arrive as pins from
 * outside the clock domain and run well below the core clock.
 */
`timescale 1ns/1ps
`include "pll_cfg_defines.svh"
module pfd_pump
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ref_div_in,
	input wire logic fb_div_in,
	pump_cfg_if.pump cfg
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic ref_s1_r, ref_s2_r, ref_d_r;
	logic fb_s1_r, fb_s2_r, fb_d_r;

	always_ff @(posedge clk)
	begin
		ref_s1_r <= ref_div_in;
		ref_s2_r <= ref_s1_r;
		ref_d_r <= ref_s2_r;
		fb_s1_r <= fb_div_in;
		fb_s2_r <= fb_s1_r;
		fb_d_r <= fb_s2_r;
	end

	logic ref_rise, fb_rise;
	assign ref_rise = ref_s2_r & ~ref_d_r;
	assign fb_rise = fb_s2_r & ~fb_d_r;

	// ------------------------------------------------------------
	// detector
	// ------------------------------------------------------------
	logic up_q_r, dn_q_r;
	logic [1:0] abl_cnt_r;
	pll_cfg_pkg::pfd_state_e st_r;

	// overlap lasts abl_width+1 cycles; that is the antibacklash pulse
	always_ff @(posedge clk)
	begin
		if (rst || !cfg.pll_on)
		begin
			up_q_r <= 1'b0;
			dn_q_r <= 1'b0;
			abl_cnt_r <= 2'h0;
			st_r <= pll_cfg_pkg::PFD_WAIT;
		end
		else
		begin
			case (st_r)
				pll_cfg_pkg::PFD_WAIT:
				begin
					up_q_r <= up_q_r | ref_rise;
					dn_q_r <= dn_q_r | fb_rise;
					abl_cnt_r <= 2'h0;
					if ((up_q_r | ref_rise) && (dn_q_r | fb_rise))
						st_r <= pll_cfg_pkg::PFD_OVERLAP;
				end
				pll_cfg_pkg::PFD_OVERLAP:
				begin
					if (abl_cnt_r == cfg.abl_width)
					begin
						up_q_r <= 1'b0;
						dn_q_r <= 1'b0;
						st_r <= pll_cfg_pkg::PFD_WAIT;
					end
					else
						abl_cnt_r <= abl_cnt_r + 2'h1;
				end
				default:
					st_r <= pll_cfg_pkg::PFD_WAIT;
			endcase
		end
	end

	// ------------------------------------------------------------
	// pump command
	// ------------------------------------------------------------
	logic up_pol, dn_pol;
	assign up_pol = cfg.polarity_neg ? dn_q_r : up_q_r;
	assign dn_pol = cfg.polarity_neg ? up_q_r : dn_q_r;

	always_ff @(posedge clk)
	begin
		if (rst || !cfg.pll_on)
		begin
			cfg.up <= 1'b0;
			cfg.down <= 1'b0;
			cfg.hiz <= 1'b1;
		end
		else
		begin
			case (cfg.pump_mode)
				`CPM_NORMAL:
				begin
					cfg.up <= up_pol;
					cfg.down <= dn_pol;
					cfg.hiz <= 1'b0;
				end
				`CPM_FORCE_UP:
				begin
					cfg.up <= 1'b1;
					cfg.down <= 1'b0;
					cfg.hiz <= 1'b0;
				end
				`CPM_FORCE_DOWN:
				begin
					cfg.up <= 1'b0;
					cfg.down <= 1'b1;
					cfg.hiz <= 1'b0;
				end
				default:
				begin
					cfg.up <= 1'b0;
					cfg.down <= 1'b0;
					cfg.hiz <= 1'b1;
				end
			endcase
		end
	end

endmodule

// ==== design/pll_cfg_defines.svh ====
/*
 * Register indices, field positions, reset values and timing counts
 * for the PLL and clock path configuration block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PLL_CFG_DEFINES_SVH
`define PLL_CFG_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define IDX_PLL_CTRL 10'h010
`define IDX_ABL 10'h017
`define IDX_CAL 10'h018
`define IDX_DIV 10'h1e0
`define IDX_SRC 10'h1e1
`define IDX_UPDATE 10'h232
`define IDX_ICP 10'h0f0
`define IDX_STATUS 10'h0f1

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PWR_MSB 1
`define PWR_LSB 0
`define CPM_MSB 6
`define CPM_LSB 4
`define POL_BIT 7
`define ABL_MSB 1
`define ABL_LSB 0
`define CAL_BIT 0
`define DIV_MSB 2
`define DIV_LSB 0
`define BYP_BIT 0
`define SRC_BIT 1
`define ICP_MSB 2
`define ICP_LSB 0

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define PWR_NORMAL 2'h0
`define PWR_DOWN 2'h1
`define CPM_HIZ 3'h0
`define CPM_FORCE_UP 3'h1
`define CPM_FORCE_DOWN 3'h2
`define CPM_NORMAL 3'h3
`define DIV_CODE_MAX 3'h4
`define RATIO_OFFSET 3'h2
`define UPDATE_GO 8'h01
`define RST_PLL_CTRL 8'h01
`define RST_DIV 8'h02
`define RST_ZERO 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CAL_CYCLES 12'h400

`endif

// ==== design/pll_cfg_pkg.sv ====
/*
 * Types shared by the configuration block and its pump controller.
 * Assumes nothing of its surroundings.
 */
package pll_cfg_pkg;

	typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_e;

	typedef enum logic [1:0] {PFD_WAIT, PFD_OVERLAP} pfd_state_e;

	typedef logic [7:0] reg8_t;

endpackage

// ==== design/pll_clock_path_config.sv ====
/*
 * Staged configuration registers for the PLL and clock routing path,
 * a classic Wishbone slave, the update transfer, VCO calibration
 * sequencing and the applied settings driven to the analog blocks.
 * Assumes a single 250 MHz core clock and a synchronous reset.
 */
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "pll_cfg_defines.svh"

module pll_clock_path_config
(
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [11:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire logic REF_DIV_IN,
	input wire logic FB_DIV_IN,
	output logic PLL_POWER_DOWN,
	output logic DIST_SOURCE_VCO,
	output logic VCO_DIV_BYPASS,
	output logic [2:0] VCO_DIV_RATIO,
	output logic [2:0] PUMP_CURRENT_CODE,
	output logic PUMP_UP,
	output logic PUMP_DOWN,
	output logic PUMP_HIZ,
	output logic VCO_CAL_BUSY
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// codes above divide-by-6 saturate rather than stop the divider,
	// since a static divider would break calibration
	function automatic logic [2:0] div_ratio(input logic [2:0] code);
		logic [2:0] c;
		c = (code > `DIV_CODE_MAX) ? `DIV_CODE_MAX : code;
		div_ratio = c + `RATIO_OFFSET;
	endfunction

	function automatic logic pll_is_on(input logic [1:0] pwr);
		pll_is_on = (pwr == `PWR_NORMAL);
	endfunction

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic [9:0] idx;
	logic req;
	logic wr_lane0;
	logic wr_stb;

	assign idx = ADR_I[11:2];
	assign req = CYC_I & STB_I & ~ACK_O;
	assign wr_lane0 = WE_I & SEL_I[0];
	assign wr_stb = req & wr_lane0;

	logic wr_pll_ctrl, wr_abl, wr_cal, wr_div, wr_src, wr_icp;
	logic update_go;

	assign wr_pll_ctrl = wr_stb && (idx == `IDX_PLL_CTRL);
	assign wr_abl = wr_stb && (idx == `IDX_ABL);
	assign wr_cal = wr_stb && (idx == `IDX_CAL);
	assign wr_div = wr_stb && (idx == `IDX_DIV);
	assign wr_src = wr_stb && (idx == `IDX_SRC);
	assign wr_icp = wr_stb && (idx == `IDX_ICP);
	assign update_go = wr_stb && (idx == `IDX_UPDATE) &&
		(DAT_I[7:0] == `UPDATE_GO);

	// ------------------------------------------------------------
	// staged registers
	// ------------------------------------------------------------
	pll_cfg_pkg::reg8_t pll_ctrl_r;
	pll_cfg_pkg::reg8_t abl_r;
	pll_cfg_pkg::reg8_t cal_r;
	pll_cfg_pkg::reg8_t div_r;
	pll_cfg_pkg::reg8_t src_r;
	pll_cfg_pkg::reg8_t icp_r;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			pll_ctrl_r <= `RST_PLL_CTRL;
			abl_r <= `RST_ZERO;
			cal_r <= `RST_ZERO;
			div_r <= `RST_DIV;
			src_r <= `RST_ZERO;
			icp_r <= `RST_ZERO;
		end
		else
		begin
			if (wr_pll_ctrl)
				pll_ctrl_r <= DAT_I[7:0];
			if (wr_abl)
				abl_r <= DAT_I[7:0];
			if (wr_cal)
				cal_r <= DAT_I[7:0];
			if (wr_div)
				div_r <= DAT_I[7:0];
			if (wr_src)
				src_r <= DAT_I[7:0];
			if (wr_icp)
				icp_r <= DAT_I[7:0];
		end
	end

	// ------------------------------------------------------------
	// applied settings
	// ------------------------------------------------------------
	// nothing below moves until an update write; staged writes alone
	// leave the analog path untouched
	logic pol_neg_r;
	logic [1:0] abl_act_r;
	logic [2:0] cpm_act_r;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			PLL_POWER_DOWN <= !pll_is_on(2'(`RST_PLL_CTRL));
			DIST_SOURCE_VCO <= 1'b0;
			VCO_DIV_BYPASS <= 1'b0;
			VCO_DIV_RATIO <= div_ratio(3'(`RST_DIV));
			PUMP_CURRENT_CODE <= 3'h0;
			pol_neg_r <= 1'b0;
			abl_act_r <= 2'h0;
			cpm_act_r <= `CPM_HIZ;
		end
		else if (update_go)
		begin
			PLL_POWER_DOWN <=
				!pll_is_on(pll_ctrl_r[`PWR_MSB:`PWR_LSB]);
			DIST_SOURCE_VCO <= src_r[`SRC_BIT];
			VCO_DIV_BYPASS <= src_r[`BYP_BIT];
			VCO_DIV_RATIO <= div_ratio(div_r[`DIV_MSB:`DIV_LSB]);
			PUMP_CURRENT_CODE <= icp_r[`ICP_MSB:`ICP_LSB];
			pol_neg_r <= pll_ctrl_r[`POL_BIT];
			abl_act_r <= abl_r[`ABL_MSB:`ABL_LSB];
			cpm_act_r <= pll_ctrl_r[`CPM_MSB:`CPM_LSB];
		end
	end

	// ------------------------------------------------------------
	// VCO calibration
	// ------------------------------------------------------------
	// a run starts only on an applied 0->1 edge of the calibration
	// bit, so a host that never clears it gets no second run
	logic cal_act_r;
	logic cal_done_r;
	logic cal_start;
	logic [11:0] cal_cnt_r;
	pll_cfg_pkg::cal_state_e cal_st_r;

	assign cal_start = update_go && cal_r[`CAL_BIT] && !cal_act_r &&
		pll_is_on(pll_ctrl_r[`PWR_MSB:`PWR_LSB]);

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			cal_act_r <= 1'b0;
		else if (update_go)
			cal_act_r <= cal_r[`CAL_BIT];
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			cal_st_r <= pll_cfg_pkg::CAL_IDLE;
			cal_cnt_r <= 12'h000;
			VCO_CAL_BUSY <= 1'b0;
			cal_done_r <= 1'b0;
		end
		else
		begin
			case (cal_st_r)
				pll_cfg_pkg::CAL_IDLE:
				begin
					if (cal_start)
					begin
						cal_st_r <= pll_cfg_pkg::CAL_RUN;
						cal_cnt_r <= 12'h000;
						VCO_CAL_BUSY <= 1'b1;
						cal_done_r <= 1'b0;
					end
				end
				pll_cfg_pkg::CAL_RUN:
				begin
					// powering down mid-run abandons it undone
					if (PLL_POWER_DOWN)
					begin
						cal_st_r <= pll_cfg_pkg::CAL_IDLE;
						VCO_CAL_BUSY <= 1'b0;
					end
					else if (cal_cnt_r == `CAL_CYCLES - 12'h001)
					begin
						cal_st_r <= pll_cfg_pkg::CAL_IDLE;
						VCO_CAL_BUSY <= 1'b0;
						cal_done_r <= 1'b1;
					end
					else
						cal_cnt_r <= cal_cnt_r + 12'h001;
				end
				default:
				begin
					cal_st_r <= pll_cfg_pkg::CAL_IDLE;
					VCO_CAL_BUSY <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// detector and pump
	// ------------------------------------------------------------
	pump_cfg_if pif();

	assign pif.pll_on = !PLL_POWER_DOWN;
	assign pif.polarity_neg = pol_neg_r;
	assign pif.abl_width = abl_act_r;
	assign pif.pump_mode = cpm_act_r;

	pfd_pump u_pfd_pump
	(
		.clk(CORE_CLK),
		.rst(RESET),
		.ref_div_in(REF_DIV_IN),
		.fb_div_in(FB_DIV_IN),
		.cfg(pif.pump)
	);

	assign PUMP_UP = pif.up;
	assign PUMP_DOWN = pif.down;
	assign PUMP_HIZ = pif.hiz;

	// ------------------------------------------------------------
	// read data and acknowledge
	// ------------------------------------------------------------
	pll_cfg_pkg::reg8_t status;
	assign status = {3'h0, VCO_DIV_BYPASS, DIST_SOURCE_VCO,
		!PLL_POWER_DOWN, cal_done_r, VCO_CAL_BUSY};

	pll_cfg_pkg::reg8_t rd_mux;

	// update register reads zero: the transfer is a one-shot action
	always_comb
	begin
		case (idx)
			`IDX_PLL_CTRL: rd_mux = pll_ctrl_r;
			`IDX_ABL: rd_mux = abl_r;
			`IDX_CAL: rd_mux = cal_r;
			`IDX_DIV: rd_mux = div_r;
			`IDX_SRC: rd_mux = src_r;
			`IDX_ICP: rd_mux = icp_r;
			`IDX_STATUS: rd_mux = status;
			default: rd_mux = `RST_ZERO;
		endcase
	end

	// one wait state; unmapped addresses still ack and read zero
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h00000000;
		end
		else
		begin
			ACK_O <= req;
			if (req && !WE_I)
				DAT_O <= {24'h000000, rd_mux};
		end
	end

endmodule

// ==== design/pump_cfg_if.sv ====
/*
 * Carries applied detector and pump settings from the register block
 * to the detector/pump controller, and its pump commands back.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pump_cfg_if;
	logic pll_on;
	logic polarity_neg;
	logic [1:0] abl_width;
	logic [2:0] pump_mode;
	logic up;
	logic down;
	logic hiz;

	modport ctrl
	(
		output pll_on, polarity_neg, abl_width, pump_mode,
		input up, down, hiz
	);

	modport pump
	(
		input pll_on, polarity_neg, abl_width, pump_mode,
		output up, down, hiz
	);
endinterface

// ==== testbench/pll_cfg_asserts.sv ====
/*
 * Port assertions for the PLL clock path configuration block.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module pll_cfg_asserts
(
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [11:0] ADR_I,
	input wire logic ACK_O,
	input wire logic PLL_POWER_DOWN,
	input wire logic DIST_SOURCE_VCO,
	input wire logic [2:0] VCO_DIV_RATIO,
	input wire logic PUMP_UP,
	input wire logic PUMP_DOWN,
	input wire logic PUMP_HIZ,
	input wire logic VCO_CAL_BUSY
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);

	// cycles busy was seen high, so a run's length is known at its end
	logic [11:0] busy_cnt_r;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET || !VCO_CAL_BUSY)
			busy_cnt_r <= 12'h000;
		else
			busy_cnt_r <= busy_cnt_r + 12'h001;
	end

	// ------------------------------------------------------------
	// bus and update transfer
	// ------------------------------------------------------------
	sequence s_req;
		CYC_I && STB_I && !ACK_O;
	endsequence
	sequence s_apply;
		ACK_O && WE_I && ADR_I == 12'h8c8;
	endsequence
	property p_ack_req;
		s_req |=> ACK_O;
	endproperty
	a_ack_req: assert property (p_ack_req)
		else $error("request not acked");
	property p_ack_one;
		ACK_O |=> !ACK_O;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("ack longer than one cycle");
	property p_ack_cause;
		ACK_O |-> $past(CYC_I && STB_I);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	property p_hold;
		!$stable({PLL_POWER_DOWN, DIST_SOURCE_VCO, VCO_DIV_RATIO})
			|-> s_apply;
	endproperty
	a_hold: assert property (p_hold)
		else $error("setting changed without update");

	// ------------------------------------------------------------
	// applied settings and calibration
	// ------------------------------------------------------------
	property p_ratio;
		VCO_DIV_RATIO inside {[3'h2:3'h6]};
	endproperty
	a_ratio: assert property (p_ratio)
		else $error("divide ratio out of range");
	property p_off_hiz;
		PLL_POWER_DOWN [*3] |-> PUMP_HIZ && !PUMP_UP && !PUMP_DOWN;
	endproperty
	a_off_hiz: assert property (p_off_hiz)
		else $error("pump active while powered down");
	property p_cal_start;
		$rose(VCO_CAL_BUSY) |-> s_apply and !PLL_POWER_DOWN;
	endproperty
	a_cal_start: assert property (p_cal_start)
		else $error("calibration began without update");
	property p_cal_len;
		$fell(VCO_CAL_BUSY) && !PLL_POWER_DOWN |-> busy_cnt_r == 12'h400;
	endproperty
	a_cal_len: assert property (p_cal_len)
		else $error("calibration length wrong");
endmodule

bind pll_clock_path_config pll_cfg_asserts u_asserts
(
	.CORE_CLK(CORE_CLK), .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I),
	.WE_I(WE_I), .ADR_I(ADR_I), .ACK_O(ACK_O),
	.PLL_POWER_DOWN(PLL_POWER_DOWN), .DIST_SOURCE_VCO(DIST_SOURCE_VCO),
	.VCO_DIV_RATIO(VCO_DIV_RATIO), .PUMP_UP(PUMP_UP),
	.PUMP_DOWN(PUMP_DOWN), .PUMP_HIZ(PUMP_HIZ),
	.VCO_CAL_BUSY(VCO_CAL_BUSY)
);

// ==== testbench/testbench.sv ====
/*
 * Self-checking bench: random staged settings, update, pump, calibration.
 * Assumes the design files and the host model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
		end \
	end
module testbench;
	logic CORE_CLK, RESET, REF_DIV_IN, FB_DIV_IN;
	logic cyc, stb, we, ack, pd, src, byp, up, dn, hiz, busy;
	logic [11:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [2:0] rat, charge_pump_current, e_rat, e_icp, c, mode, k;
	logic e_pd, e_src, e_byp, s, b;
	logic [1:0] pwr;
	logic [7:0] q;
	integer seed = 32'h5c44;
	int error_cnt, checks_done, i, n;

	pll_clock_path_config uut
	(
		.CORE_CLK(CORE_CLK), .RESET(RESET), .CYC_I(cyc), .STB_I(stb),
		.WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat),
		.ACK_O(ack), .REF_DIV_IN(REF_DIV_IN), .FB_DIV_IN(FB_DIV_IN),
		.PLL_POWER_DOWN(pd), .DIST_SOURCE_VCO(src), .VCO_DIV_BYPASS(byp),
		.VCO_DIV_RATIO(rat), .PUMP_CURRENT_CODE(charge_pump_current), .PUMP_UP(up),
		.PUMP_DOWN(dn), .PUMP_HIZ(hiz), .VCO_CAL_BUSY(busy)
	);
	wb_host host
	(
		.clk(CORE_CLK), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb),
		.we(we), .adr(adr), .sel(sel), .wdat(wdat)
	);

	initial
	begin
		CORE_CLK = 1'b0;
		forever #2 CORE_CLK = ~CORE_CLK;
	end

	function logic [2:0] ratio_of(input logic [2:0] code);
		return code > 3'h4 ? 3'h6 : code + 3'h2;
	endfunction

	function logic [2:0] pump_of(input logic off, input logic [2:0] m);
		if (off || m == 3'h0 || m > 3'h3)
			return 3'b100;
		return {1'b0, m == 3'h1, m == 3'h2};
	endfunction

	task close_out;
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		host.xfer(w, a, d, q);
		if (host.timeouts != 0)
		begin
			error_cnt++;
			close_out;
		end
	endtask

	task check_out;
		`CHK({pd, src, byp, rat, charge_pump_current}, {e_pd, e_src, e_byp, e_rat, e_icp})
	endtask

	initial
	begin
		{RESET, REF_DIV_IN, FB_DIV_IN} = 3'b100;
		{e_pd, e_src, e_byp, e_rat, e_icp} = 9'h120;
		repeat (20) @(posedge CORE_CLK);
		RESET <= 1'b0;
		@(posedge CORE_CLK);
		check_out;
		`CHK({hiz, busy}, 2'b10)
		bus(0, 12'h040, 0);
		`CHK(q, 8'h01)
		bus(1, 12'h004, 8'hff);
		bus(0, 12'h004, 0);
		`CHK(q, 8'h00)
		for (i = 0; i < 8; i++)
		begin
			{c, k, s, b, pwr} = 10'($random(seed));
			mode = i[2:0];
			if (i == 0)
				c = 3'h7;
			if (!i[0])
				pwr = 2'b00;
			if (s)
				b = 1'b0;
			bus(1, 12'h040, {1'b0, mode, 2'b00, pwr});
			bus(1, 12'h784, {6'h00, s, b});
			bus(1, 12'h780, {5'h00, c});
			bus(1, 12'h3c0, {5'h00, k});
			bus(1, 12'h8c8, 8'h03);
			check_out;
			bus(0, 12'h780, 0);
			`CHK(q, {5'h00, c})
			bus(1, 12'h8c8, 8'h01);
			{e_pd, e_src, e_byp, e_icp} = {pwr != 2'b00, s, b, k};
			e_rat = ratio_of(c);
			check_out;
			repeat (4) @(posedge CORE_CLK);
			`CHK({hiz, up, dn}, pump_of(e_pd, mode))
		end
		bus(1, 12'h784, 8'h01);
		for (i = 0; i < 6; i++)
		begin
			bus(1, 12'h05c, {6'h00, i[1:0]});
			bus(1, 12'h040, {i == 5, 7'h30});
			bus(1, 12'h8c8, 8'h01);
			REF_DIV_IN <= 1'b1;
			FB_DIV_IN <= i < 4;
			n = 0;
			repeat (12)
			begin
				@(posedge CORE_CLK);
				n += {up, dn} === 2'b11;
			end
			if (i < 4)
				`CHK(n, i + 1)
			else
				`CHK({up, dn}, i == 4 ? 2'b10 : 2'b01)
			FB_DIV_IN <= 1'b1;
			repeat (12) @(posedge CORE_CLK);
			`CHK({up, dn}, 2'b00)
			{REF_DIV_IN, FB_DIV_IN} <= 2'b00;
			repeat (6) @(posedge CORE_CLK);
		end
		bus(1, 12'h060, 8'h01);
		bus(1, 12'h8c8, 8'h01);
		n = 0;
		while (busy === 1'b1 && n < 2000)
		begin
			@(posedge CORE_CLK);
			n++;
		end
		if (n == 2000)
		begin
			error_cnt++;
			close_out;
		end
		`CHK(n, 1024)
		bus(0, 12'h3c4, 0);
		`CHK(q[2:0], 3'b110)
		bus(1, 12'h8c8, 8'h01);
		`CHK(busy, 1'b0)
		bus(1, 12'h060, 8'h00);
		bus(1, 12'h8c8, 8'h01);
		bus(1, 12'h060, 8'h01);
		bus(1, 12'h8c8, 8'h01);
		`CHK(busy, 1'b1)
		repeat (8) @(posedge CORE_CLK);
		bus(1, 12'h040, 8'h31);
		bus(1, 12'h8c8, 8'h01);
		repeat (3) @(posedge CORE_CLK);
		`CHK({busy, pd, hiz}, 3'b011)
		close_out;
	end
endmodule

// ==== testbench/wb_host.sv ====
/*
 * Host model: classic Wishbone master, one request at a time.
 * Assumes a slave that acks each request once, on clk.
 */
`timescale 1ns/1ps
module wb_host
(
	input wire logic clk,
	input wire logic ack,
	input wire logic [31:0] rdat,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [11:0] adr,
	output logic [3:0] sel,
	output logic [31:0] wdat
);
	int timeouts;

	initial
	begin
		{cyc, stb, we, sel} = 7'h00;
		adr = 12'h000;
		wdat = 32'h00000000;
	end

	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we, sel} <= {2'b11, w, 4'h1};
		adr <= a;
		wdat <= {24'h000000, d};
		@(posedge clk);
		while (ack !== 1'b1 && n < 64)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 64)
			timeouts++;
		q = rdat[7:0];
		// released lines inverted so stale values never look valid
		{cyc, stb} <= 2'b00;
		adr <= ~a;
		wdat <= ~{24'h000000, d};
	endtask
endmodule
